// >>> rtl/cood_decoder.sv
// APB-reached operand address and opcode class decoder with its register file.
// How it works
// - register operand: address 0-255 or working register.
// - indirect working register: address from its contents.
// - indirect register: contents of working or full register.
// - working bit operand: register 0-15, bit 0-7.
// - least significant bit form always selects bit 0.
// - register pair: even address, 16-bit two-register value.
// - call vector: even address, pair gives target.
// - indirect pair: 16-bit address from even pair.
// - indexed: base plus working register contents.
// - short indexed: pair plus signed 8-bit displacement.
// - long indexed: pair plus 16-bit displacement.
// - direct: 16-bit target straight from instruction.
// - relative: next instruction address plus signed displacement.
// - immediate operands, 8-bit and long 16-bit.
// - classify by opcode row and column 0-7.
// - flags layout: C Z S V D H FIS bank.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module cood_decoder (
  input wire logic pclk, // Core clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [cood_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [cood_pkg::DATA_W-1:0] pwdata, // APB write data.
  output logic [cood_pkg::DATA_W-1:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic [15:0] eff_addr, // Decoded effective address.
  output logic [15:0] operand_value, // Decoded operand value.
  output logic [2:0] bit_sel, // Decoded bit position.
  output cood_pkg::cood_class_t op_class, // Decoded instruction class.
  output logic invalid_op // Sticky invalid-opcode flag.
);
  import cood_pkg::*;

  logic [7:0] regfile [256];
  logic [7:0] flags;
  logic [7:0] opcode;
  logic [23:0] operand;
  logic [15:0] next_pc;
  cood_mode_t mode;
  logic [7:0] base_ptr;
  logic go;
  logic odd_seen;
  logic mapped;
  logic wr_en;
  logic op_wr;
  logic stat_wr;
  cood_class_t next_class;
  logic [15:0] next_ea;
  logic [15:0] next_value;
  logic [2:0] next_bit;
  logic next_odd;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic [7:0] op_c;
  logic is_work;
  logic [7:0] reg_addr;
  logic [7:0] pair_addr;
  logic [7:0] ind_addr;
  logic [DATA_W-1:0] next_rdata;

  // Reads of location 0xd5 go to the flags flops, not the plain array.
  function automatic logic [7:0] rd(input logic [7:0] a);
    rd = (a == FLAGS_INDEX) ? flags : regfile[a];
  endfunction

  // Working register n lives in the 16-byte window picked by the base pointer.
  function automatic logic [7:0] work_addr(input logic [3:0] n);
    work_addr = {base_ptr[7:4], n};
  endfunction

  // Pair value: even register is the high byte, odd register the low byte.
  function automatic logic [15:0] pair_val(input logic [7:0] a);
    pair_val = {rd({a[7:1], 1'b0}), rd({a[7:1], 1'b1})};
  endfunction

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && mapped;
  assign op_wr = wr_en && (paddr == OPCODE_ADDR);
  assign stat_wr = wr_en && (paddr == STATUS_ADDR);
  assign pslverr = psel && penable && !mapped;

  // Read mux and address decode; misaligned addresses count as unmapped.
  always_comb begin
    next_rdata = '0;
    mapped = 1'b1;
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (paddr[11:10] == REGFILE_SPACE) begin
      next_rdata = {24'h000000, rd(paddr[9:2])};
    end else begin
      case (paddr)
        OPCODE_ADDR: next_rdata = {24'h000000, opcode};
        OPERAND_ADDR: next_rdata = {8'h00, operand};
        NEXT_PC_ADDR: next_rdata = {16'h0000, next_pc};
        MODE_ADDR: next_rdata = {28'h0000000, mode};
        BASE_PTR_ADDR: next_rdata = {24'h000000, base_ptr};
        RESULT_ADDR: next_rdata = {operand_value, eff_addr};
        STATUS_ADDR: next_rdata = {24'h000000, 1'b0, op_class, bit_sel[1:0], odd_seen, invalid_op};
        default: mapped = 1'b0;
      endcase
    end
  end

  // Read data is captured in the setup cycle so that it comes from a flop; the
  // price is that a value changing during the access phase is seen as it was.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  // Register file storage holds data only, so it carries no reset.
  always_ff @(posedge pclk) begin
    if (wr_en && paddr[11:10] == REGFILE_SPACE && paddr[9:2] != FLAGS_INDEX) begin
      regfile[paddr[9:2]] <= pwdata[7:0];
    end
  end

  // Flags: C, Z, S, V, D, H, fast-interrupt status, bank select from bit 7 down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= FLAGS_RESET;
    end else if (wr_en && paddr[11:10] == REGFILE_SPACE && paddr[9:2] == FLAGS_INDEX) begin
      flags[FLAG_C_BIT] <= pwdata[FLAG_C_BIT];
      flags[FLAG_Z_BIT] <= pwdata[FLAG_Z_BIT];
      flags[FLAG_S_BIT] <= pwdata[FLAG_S_BIT];
      flags[FLAG_V_BIT] <= pwdata[FLAG_V_BIT];
      flags[FLAG_D_BIT] <= pwdata[FLAG_D_BIT];
      flags[FLAG_H_BIT] <= pwdata[FLAG_H_BIT];
      flags[FLAG_FIS_BIT] <= pwdata[FLAG_FIS_BIT];
      flags[FLAG_BANK_BIT] <= pwdata[FLAG_BANK_BIT];
    end
  end

  // Instruction staging registers written by software before the opcode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode <= OPCODE_RESET;
      operand <= '0;
      next_pc <= '0;
      mode <= MODE_REG;
      base_ptr <= BASE_PTR_RESET;
    end else if (wr_en) begin
      if (paddr == OPCODE_ADDR) begin
        opcode <= pwdata[7:0];
      end
      if (paddr == OPERAND_ADDR) begin
        operand <= pwdata[23:0];
      end
      if (paddr == NEXT_PC_ADDR) begin
        next_pc <= pwdata[15:0];
      end
      if (paddr == MODE_ADDR) begin
        mode <= cood_mode_t'(pwdata[3:0]);
      end
      if (paddr == BASE_PTR_ADDR) begin
        base_ptr <= pwdata[7:0];
      end
    end
  end

  // Writing the opcode starts one decode on the following cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go <= 1'b0;
    end else begin
      go <= op_wr;
    end
  end

  cood_opclass u_opclass (
    .opcode(opcode),
    .op_class(next_class)
  );

  // Operand fields and the addresses shared by several modes.
  assign op_a = operand[7:0];
  assign op_b = operand[15:8];
  assign op_c = operand[23:16];
  assign is_work = (op_a[7:4] == WORKING_ESCAPE);
  // Helpers read the base pointer and the array, so a process keeps these current.
  always_comb begin
    reg_addr = is_work ? work_addr(op_a[3:0]) : op_a;
    pair_addr = is_work ? work_addr({op_a[3:1], 1'b0}) : {op_a[7:1], 1'b0};
    ind_addr = rd(reg_addr);
  end

  // Effective address, operand value and bit position for the selected mode.
  always_comb begin
    next_ea = '0;
    next_value = '0;
    next_bit = 3'h0;
    next_odd = 1'b0;
    unique case (mode)
      MODE_REG: begin
        next_ea = {8'h00, reg_addr};
        next_value = {8'h00, rd(reg_addr)};
      end
      MODE_WREG: begin
        next_ea = {8'h00, work_addr(op_a[3:0])};
        next_value = {8'h00, rd(work_addr(op_a[3:0]))};
      end
      MODE_IND_WREG: begin
        next_ea = {8'h00, rd(work_addr(op_a[3:0]))};
        next_value = {8'h00, rd(rd(work_addr(op_a[3:0])))};
      end
      MODE_IND_REG: begin
        next_ea = {8'h00, ind_addr};
        next_value = {8'h00, rd(ind_addr)};
      end
      MODE_WBIT: begin
        next_ea = {8'h00, work_addr(op_a[3:0])};
        next_value = {8'h00, rd(work_addr(op_a[3:0]))};
        next_bit = op_b[2:0];
      end
      MODE_WLSB: begin
        next_ea = {8'h00, work_addr(op_a[3:0])};
        next_value = {8'h00, rd(work_addr(op_a[3:0]))};
        next_bit = 3'h0;
      end
      MODE_PAIR: begin
        next_ea = {8'h00, pair_addr};
        next_value = pair_val(pair_addr);
        next_odd = op_a[0];
      end
      MODE_CALL_VEC: begin
        // The vector has no working-register form: always a plain even address.
        next_ea = pair_val({op_a[7:1], 1'b0});
        next_value = next_ea;
        next_odd = op_a[0];
      end
      MODE_IND_PAIR: begin
        next_ea = pair_val(pair_addr);
        next_value = next_ea;
        next_odd = op_a[0];
      end
      MODE_INDEXED: begin
        next_ea = {8'h00, op_b + rd(work_addr(op_a[3:0]))};
        next_value = {8'h00, rd(op_b + rd(work_addr(op_a[3:0])))};
      end
      MODE_SHORT_IDX: begin
        next_ea = pair_val(work_addr({op_a[3:1], 1'b0})) + {{8{op_b[7]}}, op_b};
        next_odd = op_a[0];
      end
      MODE_LONG_IDX: begin
        next_ea = pair_val(work_addr({op_a[3:1], 1'b0})) + {op_b, op_c};
        next_odd = op_a[0];
      end
      MODE_DIRECT: begin
        next_ea = {op_a, op_b};
      end
      MODE_RELATIVE: begin
        next_ea = next_pc + {{8{op_a[7]}}, op_a};
      end
      MODE_IMM: begin
        next_value = {8'h00, op_a};
      end
      MODE_IMM_LONG: begin
        next_value = {op_a, op_b};
      end
    endcase
  end

  // Results latch on the decode cycle; an invalid opcode clears them rather than
  // leaving stale values that software might act on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_addr <= '0;
      operand_value <= '0;
      bit_sel <= 3'h0;
      op_class <= CLS_UPPER_HALF;
    end else if (go) begin
      op_class <= next_class;
      if (next_class == CLS_INVALID) begin
        eff_addr <= '0;
        operand_value <= '0;
        bit_sel <= 3'h0;
      end else begin
        eff_addr <= next_ea;
        operand_value <= next_value;
        bit_sel <= next_bit;
      end
    end
  end

  // Sticky status; a decode event in the clearing cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invalid_op <= 1'b0;
      odd_seen <= 1'b0;
    end else begin
      if (go && next_class == CLS_INVALID) begin
        invalid_op <= 1'b1;
      end else if (stat_wr && pwdata[STAT_INVALID_BIT]) begin
        invalid_op <= 1'b0;
      end
      if (go && next_odd) begin
        odd_seen <= 1'b1;
      end else if (stat_wr && pwdata[STAT_ODD_BIT]) begin
        odd_seen <= 1'b0;
      end
    end
  end

  // Checks on the decode results, sampled one cycle after the decode pulse, and on refused misaligned accesses.
  reg_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_REG && !is_work && next_class != CLS_INVALID |=> eff_addr == {8'h00, $past(op_a)})
    else $error("Register operand address wrong.");

  ind_work_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_IND_WREG && next_class != CLS_INVALID
    |=> eff_addr[7:0] == $past(rd({base_ptr[7:4], op_a[3:0]})))
    else $error("Indirect working register address wrong.");

  bit_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_WBIT && next_class != CLS_INVALID |=> bit_sel == $past(op_b[2:0]))
    else $error("Bit position not taken from operand.");

  lsb_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_WLSB |=> bit_sel == 3'h0)
    else $error("Least significant bit form not bit 0.");

  odd_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && (mode == MODE_PAIR || mode == MODE_CALL_VEC) && op_a[0] |=> odd_seen)
    else $error("Odd pair address not reported.");

  short_disp_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_SHORT_IDX && next_class != CLS_INVALID && op_b[7]
    |=> eff_addr == $past(pair_val({base_ptr[7:4], op_a[3:1], 1'b0})) - (16'h0100 - {8'h00, $past(op_b)}))
    else $error("Short displacement not sign extended.");

  direct_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_DIRECT && next_class != CLS_INVALID |=> eff_addr == {$past(op_a), $past(op_b)})
    else $error("Direct address wrong.");

  relative_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_RELATIVE && next_class != CLS_INVALID && op_a[7]
    |=> eff_addr == $past(next_pc) - (16'h0100 - {8'h00, $past(op_a)}))
    else $error("Relative target wrong.");

  imm_long_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && mode == MODE_IMM_LONG && next_class != CLS_INVALID |=> operand_value == {$past(op_a), $past(op_b)})
    else $error("Long immediate wrong.");

  bit_column_a: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && pwdata[7:0] != UNUSED_OPCODE && pwdata[3:0] == BIT_COLUMN |=> ##1 op_class == CLS_BIT_OP)
    else $error("Column 7 not classed as bit operation.");

  invalid_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    op_wr && pwdata[7:0] == UNUSED_OPCODE |=> ##1 invalid_op && eff_addr == 16'h0000 && op_class == CLS_INVALID)
    else $error("Unassigned opcode not flagged invalid.");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("Misaligned access not refused.");
endmodule

// >>> rtl/cood_opclass.sv
// Opcode row and column classifier for the lower-nibble 0 to 7 half of the map.
`timescale 1ns/1ps
module cood_opclass (
  input wire logic [7:0] opcode, // Opcode byte.
  output cood_pkg::cood_class_t op_class // Instruction class.
);
  import cood_pkg::*;

  // The upper nibble is the row; the column decides the class here, except for the unused opcode 0xd5.
  always_comb begin
    if (opcode[3]) begin
      op_class = CLS_UPPER_HALF;
    end else if (opcode == UNUSED_OPCODE) begin
      op_class = CLS_INVALID;
    end else begin
      unique case (opcode[2:0])
        3'h0: op_class = CLS_SINGLE_REG;
        3'h1: op_class = CLS_SINGLE_IND;
        3'h7: op_class = CLS_BIT_OP;
        3'h2, 3'h3, 3'h4, 3'h5, 3'h6: op_class = CLS_TWO_OP;
      endcase
    end
  end
endmodule

// >>> rtl/cood_pkg.sv
// Shared constants and types for the operand and opcode decoder.
package cood_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register file occupies byte addresses 0x000 to 0x3fc, one entry per word.
  localparam logic [1:0] REGFILE_SPACE = 2'h0;
  localparam logic [7:0] FLAGS_INDEX = 8'hd5;
  localparam logic [ADDR_W-1:0] OPCODE_ADDR = 12'h400;
  localparam logic [ADDR_W-1:0] OPERAND_ADDR = 12'h404;
  localparam logic [ADDR_W-1:0] NEXT_PC_ADDR = 12'h408;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 12'h40c;
  localparam logic [ADDR_W-1:0] BASE_PTR_ADDR = 12'h410;
  localparam logic [ADDR_W-1:0] RESULT_ADDR = 12'h414;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h418;
  // Flag bit positions.
  localparam int FLAG_C_BIT = 7;
  localparam int FLAG_Z_BIT = 6;
  localparam int FLAG_S_BIT = 5;
  localparam int FLAG_V_BIT = 4;
  localparam int FLAG_D_BIT = 3;
  localparam int FLAG_H_BIT = 2;
  localparam int FLAG_FIS_BIT = 1;
  localparam int FLAG_BANK_BIT = 0;
  // Status bit positions.
  localparam int STAT_INVALID_BIT = 0;
  localparam int STAT_ODD_BIT = 1;
  // Reset values.
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BASE_PTR_RESET = 8'hc0;
  localparam logic [7:0] OPCODE_RESET = 8'hff;
  // An 8-bit register operand whose upper nibble is this names a working register.
  localparam logic [3:0] WORKING_ESCAPE = 4'hc;
  localparam logic [7:0] UNUSED_OPCODE = 8'hd5;
  localparam logic [3:0] BIT_COLUMN = 4'h7;
  typedef enum logic [3:0] {
    MODE_REG, MODE_WREG, MODE_IND_WREG, MODE_IND_REG, MODE_WBIT, MODE_WLSB, MODE_PAIR, MODE_CALL_VEC,
    MODE_IND_PAIR, MODE_INDEXED, MODE_SHORT_IDX, MODE_LONG_IDX, MODE_DIRECT, MODE_RELATIVE, MODE_IMM,
    MODE_IMM_LONG
  } cood_mode_t;
  typedef enum logic [2:0] {
    CLS_SINGLE_REG, CLS_SINGLE_IND, CLS_TWO_OP, CLS_BIT_OP, CLS_UPPER_HALF, CLS_INVALID
  } cood_class_t;
endpackage

// >>> test/cood_prog_mem.sv
// Behavioural program memory that hands instruction bytes to the bench.
`timescale 1ns/1ps
module cood_prog_mem (
  input wire logic [15:0] fetch_addr, // Byte address in program space.
  output logic [7:0] fetch_data // Byte stored at that address.
);
  logic [7:0] mem [0:255];
  // Fill with a fixed scrambled pattern; some byte values repeat, so not every value shows up.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'((i * 37 + 11) ^ (i >> 3));
    end
  end
  // The upper address byte is folded in so that far pages differ too.
  assign fetch_data = mem[fetch_addr[7:0]] ^ fetch_addr[15:8];
endmodule

// >>> test/cpu_operand_and_opcode_decode_tb.sv
// Self-checking bench for the operand and opcode decoder with a reference model.
`timescale 1ns/1ps
module cpu_operand_and_opcode_decode_tb;
  import cood_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, invalid_op;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [15:0] eff_addr, operand_value, pm_addr;
  logic [7:0] pm_data;
  logic [2:0] bit_sel;
  cood_class_t op_class;
  logic err;
  int n_mismatch, compares, rf[256];
  logic [31:0] seed;
  int k, mode, bp, pc, a, b, c, wa, ra, ea, val, bs, odd, cls, msk;

  cood_decoder i_cood_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eff_addr(eff_addr), .operand_value(operand_value), .bit_sel(bit_sel),
    .op_class(op_class), .invalid_op(invalid_op));
  cood_prog_mem i_cood_prog_mem (.fetch_addr(pm_addr), .fetch_data(pm_data));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int sx(input int v);
    return (v > 127) ? v - 256 : v;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high, bounded by a count.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Hang guard sized well above the expected run of some 7500 cycles.
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    seed = 32'd47458;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    pm_addr = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, a read-only result, and refused addresses.
    apb(0, {2'h0, FLAGS_INDEX, 2'h0}, 0);
    chk(rd, {24'h0, FLAGS_RESET});
    apb(0, BASE_PTR_ADDR, 0);
    chk(rd, {24'h0, BASE_PTR_RESET});
    apb(0, STATUS_ADDR, 0);
    chk(rd, {25'h0, CLS_UPPER_HALF, 4'h0});
    apb(1, RESULT_ADDR, 32'h1234abcd);
    apb(0, RESULT_ADDR, 0);
    chk(rd, 32'h0);
    apb(0, 12'h41c, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1, 12'h402, 32'h55);
    chk({31'h0, err}, 32'h1);
    // The refused write next to the opcode must leave it at its reset value.
    apb(0, OPCODE_ADDR, 0);
    chk(rd, {24'h0, OPCODE_RESET});
    // Walk a one through the flags register; each bit must stand alone.
    for (int i = 0; i < 8; i++) begin
      apb(1, {2'h0, FLAGS_INDEX, 2'h0}, 32'(1 << i));
      apb(0, {2'h0, FLAGS_INDEX, 2'h0}, 0);
      chk(rd, 32'(1 << i));
    end
    // Fill the register file with random bytes and mirror them in the model.
    for (int i = 0; i < 256; i++) begin
      rf[i] = xorshift() & 255;
      apb(1, 12'(i * 4), rf[i]);
    end
    // Every opcode once, with modes cycling and random operands and pointers.
    for (k = 0; k < 256; k++) begin
      mode = (k & 15) ^ (k >> 4);
      bp = xorshift() & 255;
      pc = xorshift() & 'hffff;
      pm_addr = 16'(pc); #1 a = pm_data;
      pm_addr = 16'(pc + 1); #1 b = pm_data;
      pm_addr = 16'(pc + 2); #1 c = pm_data;
      if (k & 16) a = (a & 15) | 'hc0;
      wa = (bp & 'hf0) | (a & 15);
      ra = ((a >> 4) == 12) ? wa : a;
      {ea, val, bs, odd} = '0;
      case (mode)
        0: begin
          ea = ra;
          val = rf[ra];
        end
        1: begin
          ea = wa;
          val = rf[wa];
        end
        2: begin
          ea = rf[wa];
          val = rf[rf[wa]];
        end
        3: begin
          ea = rf[ra];
          val = rf[rf[ra]];
        end
        4: begin
          ea = wa;
          val = rf[wa];
          bs = b & 7;
        end
        5: begin
          ea = wa;
          val = rf[wa];
        end
        6: begin
          ea = ra & 'hfe;
          val = rf[ea] * 256 + rf[ea | 1];
          odd = a & 1;
        end
        7: begin
          ea = rf[a & 'hfe] * 256 + rf[a | 1];
          val = ea;
          odd = a & 1;
        end
        8: begin
          ea = rf[ra & 'hfe] * 256 + rf[ra | 1];
          val = ea;
          odd = a & 1;
        end
        9: begin
          ea = (b + rf[wa]) & 255;
          val = rf[ea];
        end
        10: begin
          ea = (rf[wa & 'hfe] * 256 + rf[wa | 1] + sx(b)) & 'hffff;
          odd = a & 1;
        end
        11: begin
          ea = (rf[wa & 'hfe] * 256 + rf[wa | 1] + b * 256 + c) & 'hffff;
          odd = a & 1;
        end
        12: ea = a * 256 + b;
        13: ea = (pc + 3 + sx(a)) & 'hffff;
        14: val = a;
        default: val = a * 256 + b;
      endcase
      msk = 'h7f;
      if (k == 'hd5) begin
        cls = CLS_INVALID;
        {ea, val, bs} = '0;
        msk = 'h7d;
      end else if (k & 8) begin
        cls = CLS_UPPER_HALF;
      end else begin
        case (k & 7)
          0: cls = CLS_SINGLE_REG;
          1: cls = CLS_SINGLE_IND;
          7: cls = CLS_BIT_OP;
          default: cls = CLS_TWO_OP;
        endcase
      end
      apb(1, OPERAND_ADDR, {8'h0, 8'(c), 8'(b), 8'(a)});
      apb(1, MODE_ADDR, mode);
      apb(1, NEXT_PC_ADDR, pc + 3);
      apb(1, BASE_PTR_ADDR, bp);
      apb(1, STATUS_ADDR, 32'h3);
      apb(1, OPCODE_ADDR, k);
      // Results land one edge after the opcode write is taken; the check waits two.
      repeat (2) @(posedge pclk);
      #1;
      chk({16'h0, eff_addr}, ea);
      chk({16'h0, operand_value}, val);
      chk({29'h0, bit_sel}, bs);
      chk(32'(op_class), cls);
      chk({31'h0, invalid_op}, k == 'hd5);
      apb(0, RESULT_ADDR, 0);
      chk(rd, val * 65536 + ea);
      apb(0, STATUS_ADDR, 0);
      chk(rd & msk, ((cls << 4) | ((bs & 3) << 2) | (odd << 1) | (k == 'hd5)) & msk);
    end
    end_of_test();
  end
endmodule
